/* tpw_consts.svh */
`ifndef TPW_CONSTS_SVH
`define TPW_CONSTS_SVH

// Register byte addresses on the APB.
`define ADDR_OPTION 12'h000
`define ADDR_COUNTER 12'h004
`define ADDR_WDOG 12'h008
`define ADDR_IRQ_STATUS 12'h00C
`define ADDR_IRQ_MASK 12'h010
`define ADDR_CONTROL 12'h014

// Option register field positions.
`define OPT_CLK_SRC 5
`define OPT_EDGE_SEL 4
`define OPT_DIV_ASSIGN 3
`define OPT_DIV_SEL_HI 2
`define OPT_DIV_SEL_LO 0

// Reset values.
`define OPTION_RST 8'hFF
`define COUNTER_RST 8'h00
`define WDOG_RST 8'h00
`define MASK_RST 2'h0

// Status and mask bit positions.
`define IRQ_WRAP 0
`define IRQ_WDOG 1

// Instruction-cycle length in system clocks.
`define INSTR_CYCLE_CLKS 8'h01

`endif

/* tpw_pkg.sv */
package tpw_pkg;

  // Option register layout.
  typedef struct packed {
    logic [1:0] spare;
    logic clk_src;
    logic edge_sel;
    logic divider_assign;
    logic [2:0] divide_select;
  } option_t;

  // APB request as seen by the slave.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // Interrupt-return command from the core.
  typedef enum logic [1:0] {
    RET_NONE = 2'b00,
    RET_PLAIN = 2'b01,
    RET_ADD = 2'b10
  } ret_cmd_t;

endpackage : tpw_pkg

/* tpw_divider.sv */
`timescale 1ns/1ps
`include "tpw_consts.svh"

// Shared 8-bit divider; its count is private and never reaches the bus.
module tpw_divider (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Control
  input wire logic [2:0] divide_select,
  input wire logic clr,
  input wire logic tick_in,
  // Output
  output logic tick_out
);

  logic [7:0] div_cnt_r;
  logic [7:0] div_cnt_nxt;
  logic [7:0] div_last;

  // Ratio 2^(n+1): terminal count is that minus one.
  assign div_last = 8'((9'h002 << divide_select) - 9'h001);
  assign div_cnt_nxt = 8'(div_cnt_r + 8'h01);

  // Count input ticks; pulse once each full ratio.
  always_ff @(posedge sys_clk) begin
    if (srst || clr) begin
      div_cnt_r <= 8'h00;
    end else if (tick_in) begin
      div_cnt_r <= (div_cnt_r >= div_last) ? 8'h00 : div_cnt_nxt;
    end
  end

  assign tick_out = tick_in && (div_cnt_r >= div_last);

endmodule : tpw_divider

/* tpw_timer.sv */
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "tpw_consts.svh"

// Behaviour
// - Eight-bit counter plus separate eight-bit watchdog.
// - Source bit zero selects instruction clock.
// - Count each cycle, or each divider output.
// - Source bit one counts external pin edges.
// - Edge bit: one falling, zero rising.
// - Counter wrap to zero raises interrupt.
// - No overflow pending flag in counter path.
// - Divider extends counter range to sixteen bits.
// - Assign bit one: watchdog drives divider.
// - Assign bit zero: divider clocks counter.
// - Divider serves only one side.
// - Divider count is never bus-visible.
// - Add-return variant adds working value to counter.
module tpw_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // APB slave
  input wire tpw_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External count pin, synchronous to sys_clk
  input wire logic count_pin,
  // Core interface
  input wire tpw_pkg::ret_cmd_t ret_cmd,
  input wire logic [7:0] work_reg,
  input wire logic wdog_clear,
  // Outputs
  output logic counter_wrap_irq,
  output logic wdog_reset_req,
  output logic irq
);
  import tpw_pkg::*;

  option_t option_r;
  logic [7:0] counter_r;
  logic [7:0] counter_nxt;
  logic [7:0] wdog_r;
  logic [1:0] irq_status_r;
  logic [1:0] irq_mask_r;
  logic wdog_enable_r;
  logic [7:0] icyc_cnt_r;
  logic instr_tick;
  logic pin_d_r;
  logic pin_edge;
  logic cnt_src_tick;
  logic counter_tick;
  logic wdog_wrap;
  logic wdog_tick;
  logic div_in;
  logic div_out;
  logic div_clr;
  logic wrap_event;
  logic wdog_event;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rd_mux;

  // Instruction-cycle enable from a divider of the system clock.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      icyc_cnt_r <= 8'h00;
    end else if (icyc_cnt_r >= `INSTR_CYCLE_CLKS - 8'h01) begin
      icyc_cnt_r <= 8'h00;
    end else begin
      icyc_cnt_r <= 8'(icyc_cnt_r + 8'h01);
    end
  end

  assign instr_tick = (icyc_cnt_r >= `INSTR_CYCLE_CLKS - 8'h01);

  // Previous pin level; the pin is taken as already synchronous.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pin_d_r <= 1'b0;
    end else begin
      pin_d_r <= count_pin;
    end
  end

  // Edge select picks falling when set, rising when clear.
  assign pin_edge = option_r.edge_sel ? (pin_d_r && !count_pin) : (!pin_d_r && count_pin);

  // Source select between the instruction clock and the pin edge.
  assign cnt_src_tick = option_r.clk_src ? pin_edge : instr_tick;

  // The divider follows exactly one side, chosen by the assign bit.
  assign wdog_tick = wdog_enable_r && instr_tick;
  assign wdog_wrap = wdog_tick && (wdog_r == 8'hFF);
  assign div_in = option_r.divider_assign ? wdog_wrap : cnt_src_tick;

  // Reassigning the divider restarts it so no stale count leaks across.
  assign div_clr = apb_req.psel && apb_req.penable && apb_req.pwrite
                   && (apb_req.paddr == `ADDR_OPTION)
                   && (apb_req.pwdata[`OPT_DIV_ASSIGN] != option_r.divider_assign);

  tpw_divider u_divider (
    .sys_clk(sys_clk),
    .srst(srst),
    .divide_select(option_r.divide_select),
    .clr(div_clr),
    .tick_in(div_in),
    .tick_out(div_out)
  );

  // Counter advances directly or through the divider's output.
  assign counter_tick = option_r.divider_assign ? cnt_src_tick : div_out;
  assign wrap_event = counter_tick && (counter_r == 8'hFF);

  // Watchdog terminal count is its wrap, through the divider if assigned.
  assign wdog_event = option_r.divider_assign ? div_out : wdog_wrap;

  // APB decode; every access completes in the access phase with no wait.
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_en = apb_req.psel && apb_req.penable && !apb_req.pwrite;
  assign pready = 1'b1;
  assign addr_ok = (apb_req.paddr == `ADDR_OPTION) || (apb_req.paddr == `ADDR_COUNTER)
                   || (apb_req.paddr == `ADDR_WDOG) || (apb_req.paddr == `ADDR_IRQ_STATUS)
                   || (apb_req.paddr == `ADDR_IRQ_MASK) || (apb_req.paddr == `ADDR_CONTROL);
  assign pslverr = apb_req.psel && apb_req.penable && !addr_ok;

  // Option register.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      option_r <= `OPTION_RST;
    end else if (wr_en && apb_req.paddr == `ADDR_OPTION) begin
      option_r <= option_t'(apb_req.pwdata[7:0]);
    end
  end

  // Next counter value; add-return adds to the ticked value; a bus write overrides both.
  always_comb begin
    counter_nxt = counter_r;
    if (counter_tick) begin
      counter_nxt = 8'(counter_r + 8'h01);
    end
    if (ret_cmd == RET_ADD) begin
      counter_nxt = 8'(counter_nxt + work_reg);
    end
    if (wr_en && apb_req.paddr == `ADDR_COUNTER) begin
      counter_nxt = apb_req.pwdata[7:0];
    end
  end

  // The counter holds no overflow flag; software reads the value itself.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      counter_r <= `COUNTER_RST;
    end else begin
      counter_r <= counter_nxt;
    end
  end

  // Watchdog counter and its enable.
  always_ff @(posedge sys_clk) begin
    if (srst || wdog_clear) begin
      wdog_r <= `WDOG_RST;
    end else if (wdog_tick) begin
      wdog_r <= 8'(wdog_r + 8'h01);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wdog_enable_r <= 1'b0;
    end else if (wr_en && apb_req.paddr == `ADDR_CONTROL) begin
      wdog_enable_r <= apb_req.pwdata[0];
    end
  end

  // Reset request is a registered one-cycle pulse.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wdog_reset_req <= 1'b0;
      counter_wrap_irq <= 1'b0;
    end else begin
      wdog_reset_req <= wdog_event;
      counter_wrap_irq <= wrap_event;
    end
  end

  // Sticky status, cleared by reading it; a new event wins over the clear.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_status_r <= 2'h0;
    end else begin
      if (rd_en && apb_req.paddr == `ADDR_IRQ_STATUS) begin
        irq_status_r <= {wdog_event, wrap_event};
      end else begin
        irq_status_r <= irq_status_r | {wdog_event, wrap_event};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_mask_r <= `MASK_RST;
    end else if (wr_en && apb_req.paddr == `ADDR_IRQ_MASK) begin
      irq_mask_r <= apb_req.pwdata[1:0];
    end
  end

  assign irq = |(irq_status_r & irq_mask_r);

  // Read multiplexer; the divider count has no address.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (apb_req.paddr)
      `ADDR_OPTION: rd_mux = {24'h00_0000, option_r};
      `ADDR_COUNTER: rd_mux = {24'h00_0000, counter_r};
      `ADDR_WDOG: rd_mux = {24'h00_0000, wdog_r};
      `ADDR_IRQ_STATUS: rd_mux = {30'h0000_0000, irq_status_r};
      `ADDR_IRQ_MASK: rd_mux = {30'h0000_0000, irq_mask_r};
      `ADDR_CONTROL: rd_mux = {31'h0000_0000, wdog_enable_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign prdata = rd_mux;

endmodule : tpw_timer

/* tpw_timer_sva.sv */
`timescale 1ns/1ps
// Port-level checks on the timer block.
module tpw_timer_chk
  import tpw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Bus and outputs
  input wire tpw_pkg::apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic counter_wrap_irq,
  input wire logic wdog_reset_req,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic acc;
  logic mapped;
  // Access phase and decode of the six mapped words.
  assign acc = apb_req.psel && apb_req.penable;
  assign mapped = apb_req.paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014};
  chk_pready_high: assert property (pready)
    else $error("pready low");
  chk_bad_addr: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  chk_good_addr: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access refused");
  chk_err_zero: assert property (acc && pslverr && !apb_req.pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  chk_upper_zero: assert property (acc && !apb_req.pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_wrap_pulse: assert property (counter_wrap_irq |=> !counter_wrap_irq)
    else $error("wrap pulse too long");
  chk_wdog_gap: assert property (wdog_reset_req |=> !wdog_reset_req [*8])
    else $error("watchdog pulses too close");
  chk_reset_quiet: assert property ($past(srst) |-> !counter_wrap_irq && !wdog_reset_req && !irq)
    else $error("outputs active after reset");
endmodule : tpw_timer_chk

bind tpw_timer tpw_timer_chk u_chk (.sys_clk, .srst, .apb_req, .prdata, .pready, .pslverr,
  .counter_wrap_irq, .wdog_reset_req, .irq);

/* tpw_pin_model.sv */
`timescale 1ns/1ps
// Far-side pulse source; the pin stands still while run is low.
module tpw_pin_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Control and pin
  input wire logic run,
  output logic count_pin
);
  logic ph_r;
  // Toggle every second cycle so each level outlasts the edge detector.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ph_r <= 1'b0;
      count_pin <= 1'b0;
    end else if (run) begin
      ph_r <= ~ph_r;
      if (ph_r) begin
        count_pin <= ~count_pin;
      end
    end
  end
endmodule : tpw_pin_model

/* tb_top.sv */
`timescale 1ns/1ps
`include "tpw_consts.svh"
module tb_top;
  import tpw_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  apb_req_t req = '0;
  ret_cmd_t ret_cmd = RET_NONE;
  logic [7:0] work_reg = 8'h00;
  logic wdog_clear = 1'b0;
  logic run = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, count_pin, wrap, wreq, irq, rd_e;
  logic [31:0] rd_d;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  tpw_timer DUT (.sys_clk, .srst, .apb_req(req), .prdata, .pready, .pslverr, .count_pin,
    .ret_cmd, .work_reg, .wdog_clear, .counter_wrap_irq(wrap), .wdog_reset_req(wreq), .irq);
  tpw_pin_model u_pin (.sys_clk, .srst, .run, .count_pin);
  // Free-running 100 MHz clock.
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // Cycle ceiling well above the total scenario length.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  // One APB transfer; data is taken at the edge where pready is seen high, before registers move.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd_d = prdata;
    rd_e = pslverr;
    req <= '0;
  endtask : xfer
  // Counts edges until the chosen pulse shows, bounded.
  task automatic gap(input logic wd, output int k);
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while ((wd ? wreq : wrap) !== 1'b1 && k < 1100);
  endtask : gap
  task automatic t_reset();
    xfer(1'b0, `ADDR_OPTION, 0);
    check(rd_d, {24'h0, `OPTION_RST});
    xfer(1'b0, `ADDR_WDOG, 0);
    check(rd_d, 32'h0);
    xfer(1'b0, 12'h018, 0);
    check(rd_e, 32'h1);
    check(rd_d, 32'h0);
  endtask : t_reset
  // Plain counting, then divided counting over a 256-cycle span.
  task automatic t_prescale();
    logic [7:0] c0;
    logic [7:0] dl;
    int e;
    xfer(1'b1, `ADDR_OPTION, 32'h08);
    xfer(1'b0, `ADDR_COUNTER, 0);
    c0 = rd_d[7:0];
    xfer(1'b0, `ADDR_COUNTER, 0);
    check(32'(8'(rd_d[7:0] - c0)), 32'h3);
    for (int n = 0; n < 8; n++) begin
      e = 256 >> (n + 1);
      xfer(1'b1, `ADDR_OPTION, 32'(n));
      xfer(1'b0, `ADDR_COUNTER, 0);
      c0 = rd_d[7:0];
      repeat (253) @(posedge sys_clk);
      xfer(1'b0, `ADDR_COUNTER, 0);
      dl = rd_d[7:0] - c0;
      check(32'(dl + 1 >= e && dl <= e + 1), 32'h1);
    end
  endtask : t_prescale
  // Pin toggles from a known level; only the chosen edge counts.
  task automatic t_pin(input logic [7:0] opt, input int tg, input logic [7:0] e);
    xfer(1'b1, `ADDR_OPTION, {24'h0, opt});
    xfer(1'b1, `ADDR_COUNTER, 0);
    @(posedge sys_clk);
    run <= 1'b1;
    repeat (2 * tg) @(posedge sys_clk);
    run <= 1'b0;
    repeat (4) @(posedge sys_clk);
    xfer(1'b0, `ADDR_COUNTER, 0);
    check(rd_d, {24'h0, e});
  endtask : t_pin
  task automatic t_ret();
    xfer(1'b1, `ADDR_COUNTER, 32'h10);
    @(posedge sys_clk);
    ret_cmd <= RET_ADD;
    work_reg <= 8'h25;
    @(posedge sys_clk);
    ret_cmd <= RET_PLAIN;
    @(posedge sys_clk);
    ret_cmd <= RET_NONE;
    xfer(1'b0, `ADDR_COUNTER, 0);
    check(rd_d, 32'h35);
  endtask : t_ret
  // Wrap sets status and irq; a read clears it and the mask gates irq.
  task automatic t_irq();
    int k;
    xfer(1'b1, `ADDR_OPTION, 32'h08);
    xfer(1'b1, `ADDR_IRQ_MASK, 32'h1);
    xfer(1'b1, `ADDR_COUNTER, 32'hF0);
    gap(1'b0, k);
    check(wrap, 1'b1);
    @(posedge sys_clk);
    #1;
    check(irq, 1'b1);
    xfer(1'b0, `ADDR_IRQ_STATUS, 0);
    check(rd_d, 32'h1);
    #1;
    check(irq, 1'b0);
    xfer(1'b1, `ADDR_IRQ_MASK, 32'h0);
    gap(1'b0, k);
    @(posedge sys_clk);
    #1;
    check({wrap, irq}, 2'b00);
  endtask : t_irq
  // Spacing of watchdog requests with and without the divider.
  task automatic t_wdog(input logic [7:0] opt, input int e);
    int k;
    xfer(1'b1, `ADDR_OPTION, {24'h0, opt});
    xfer(1'b1, `ADDR_CONTROL, 32'h1);
    gap(1'b1, k);
    gap(1'b1, k);
    check(k, e);
  endtask : t_wdog
  initial begin
    repeat (12) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset();
    t_prescale();
    t_pin(8'h28, 9, 8'h05);
    t_pin(8'h38, 7, 8'h04);
    t_ret();
    t_irq();
    t_wdog(8'h08, 512);
    t_wdog(8'h00, 256);
    stop_test();
  end
endmodule : tb_top
